// ---- rtl/dmacc_ahb_slave.sv ----
// Purpose: AHB-Lite slave front end of the dma channel control core
// Assumes: single word transfers; one slave drives hready
// Notes:   writes take no wait state, reads take one
`timescale 1ns/1ps
`include "dmacc_params.svh"
module dmacc_ahb_slave (
    // clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    // AHB-Lite
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic [31:0]                  hrdata,
    // register side
    output dmacc_pkg::dmacc_reg_acc_s    regAcc,
    input  wire logic [31:0]             regRdata
);
    import dmacc_pkg::*;

    logic       pendWr_q;
    logic       pendRd_q;
    logic [7:0] addr_q;
    logic       readyOut_q;
    logic [31:0] rdata_q;

    // non-word sizes are not taken and complete as OKAY
    wire take   = hsel & htrans[1] & hready & (hsize == `DMACC_HSIZE_WORD);
    // the wait cycle lets a write just before a read land first
    wire rdNow  = pendRd_q & ~readyOut_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pendWr_q   <= 1'b0;
            pendRd_q   <= 1'b0;
            addr_q     <= 8'h00;
            readyOut_q <= 1'b1;
            rdata_q    <= `DMACC_WORD_RST;
        end else begin
            pendWr_q   <= take & hwrite;
            pendRd_q   <= take & ~hwrite;
            readyOut_q <= ~(take & ~hwrite);
            if (take) begin
                addr_q <= haddr[7:0];
            end
            if (rdNow) begin
                rdata_q <= regRdata;
            end
        end
    end

    assign regAcc.wr    = pendWr_q;
    assign regAcc.rd    = rdNow;
    assign regAcc.addr  = addr_q;
    assign regAcc.wdata = hwdata;
    assign hreadyout    = readyOut_q;
    assign hresp        = 1'b0;
    assign hrdata       = rdata_q;
endmodule : dmacc_ahb_slave

// ---- rtl/dmacc_channel_ctrl.sv ----
// Purpose: control and status core of one dma channel
// Assumes: triggers and memory bus synchronous to sys_clk
// Notes:   one message runs until a source or destination count wraps
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "dmacc_params.svh"

// Behaviour
// (RQ1) A permitted start trigger during an active message sets overrun.
// (RQ2) Control bit 7 enables the channel when one and turns it off at zero.
// (RQ3) Hardware start triggers begin transfers only while bit 6 is set.
// (RQ4) Control bit 5 reads one exactly while a transaction is under way.
// (RQ5) Hardware abort triggers end transfers only while bit 2 is set.
// (RQ6) Read-only bit 0 is one while a fetched word awaits its write.
// (RQ7) Control bits 4, 3 and 1 always read as zero.
// (RQ8) Each step reads the source then writes the destination, advancing both pointers and counts and reloading a pair with its done flag when its count runs out.
module dmacc_channel_ctrl (
    // clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    // AHB-Lite register bus
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic [31:0]                  hrdata,
    // trigger sources
    input  wire logic                    startTrig,
    input  wire logic                    abortTrig,
    // system memory bus
    output dmacc_pkg::dmacc_mem_req_s    memReq,
    input  wire logic                    memAck,
    input  wire logic [7:0]              memRdata,
    // interrupt
    output logic                         irq
);
    import dmacc_pkg::*;

    // ****************************************************************
    // decoding helper
    // ****************************************************************
    function automatic logic regHit(input logic [7:0] a,
                                    input logic [7:0] off);
        regHit = (a[7:2] == off[7:2]);
    endfunction : regHit

    // ****************************************************************
    // state
    // ****************************************************************
    dmacc_reg_acc_s              regAcc;
    logic [31:0]                 regRdata;
    dmacc_state_e                state_q;
    dmacc_state_e                state_d;
    logic                        enable_q;
    logic                        hwStartPermit_q;
    logic                        transactionActive_q;
    logic                        transactionActive_d;
    logic                        hwAbortPermit_q;
    logic                        heldDataPending_q;
    logic                        heldDataPending_d;
    logic [`DMACC_ADDR_W-1:0]    srcStart_q;
    logic [`DMACC_ADDR_W-1:0]    dstStart_q;
    logic [`DMACC_CNT_W-1:0]     srcSize_q;
    logic [`DMACC_CNT_W-1:0]     dstSize_q;
    logic [`DMACC_ADDR_W-1:0]    srcPtr_q;
    logic [`DMACC_ADDR_W-1:0]    srcPtr_d;
    logic [`DMACC_ADDR_W-1:0]    dstPtr_q;
    logic [`DMACC_ADDR_W-1:0]    dstPtr_d;
    logic [`DMACC_CNT_W-1:0]     srcCnt_q;
    logic [`DMACC_CNT_W-1:0]     srcCnt_d;
    logic [`DMACC_CNT_W-1:0]     dstCnt_q;
    logic [`DMACC_CNT_W-1:0]     dstCnt_d;
    logic [`DMACC_DATA_W-1:0]    holdBuf_q;
    dmacc_int_t                  intStat_q;
    dmacc_int_t                  intStat_d;
    dmacc_int_t                  intMask_q;
    dmacc_int_t                  intEvent;
    logic                        irq_q;
    dmacc_mem_req_s              memReq_q;
    dmacc_mem_req_s              memReq_d;

    // ****************************************************************
    // bus slave
    // ****************************************************************
    dmacc_ahb_slave u_slave (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .regAcc    (regAcc),
        .regRdata  (regRdata)
    );

    // ****************************************************************
    // register decode
    // ****************************************************************
    wire [31:0] wd       = regAcc.wdata;
    wire hitCtrl   = regHit(regAcc.addr, `DMACC_OFF_CTRL);
    wire hitSStart = regHit(regAcc.addr, `DMACC_OFF_SSTART);
    wire hitSSize  = regHit(regAcc.addr, `DMACC_OFF_SSIZE);
    wire hitDStart = regHit(regAcc.addr, `DMACC_OFF_DSTART);
    wire hitDSize  = regHit(regAcc.addr, `DMACC_OFF_DSIZE);
    wire hitSPtr   = regHit(regAcc.addr, `DMACC_OFF_SPTR);
    wire hitDPtr   = regHit(regAcc.addr, `DMACC_OFF_DPTR);
    wire hitSCnt   = regHit(regAcc.addr, `DMACC_OFF_SCNT);
    wire hitDCnt   = regHit(regAcc.addr, `DMACC_OFF_DCNT);
    wire hitBuf    = regHit(regAcc.addr, `DMACC_OFF_BUF);
    wire hitIStat  = regHit(regAcc.addr, `DMACC_OFF_ISTAT);
    wire hitIMask  = regHit(regAcc.addr, `DMACC_OFF_IMASK);

    wire wrCtrl    = regAcc.wr & hitCtrl;
    wire wrIStat   = regAcc.wr & hitIStat;
    wire wrIMask   = regAcc.wr & hitIMask;
    // pointer setup is locked while a message runs
    wire wrSStart  = regAcc.wr & hitSStart & ~transactionActive_q;
    wire wrSSize   = regAcc.wr & hitSSize & ~transactionActive_q;
    wire wrDStart  = regAcc.wr & hitDStart & ~transactionActive_q;
    wire wrDSize   = regAcc.wr & hitDSize & ~transactionActive_q;

    // ****************************************************************
    // start, abort and step events
    // ****************************************************************
    // (RQ2) software enable and start
    wire swStart   = wrCtrl & wd[`DMACC_CTRL_ACT] & wd[`DMACC_CTRL_EN];
    wire swOff     = wrCtrl & ~wd[`DMACC_CTRL_EN];
    // (RQ3) hardware start gating
    wire hwStart   = startTrig & hwStartPermit_q & enable_q;
    // (RQ5) hardware abort gating
    wire abortHit  = abortTrig & hwAbortPermit_q & transactionActive_q;
    wire killAll   = abortHit | swOff;
    wire beginMsg  = ~transactionActive_q & ~killAll & (swStart | hwStart);
    // (RQ1) trigger while busy
    wire overrun   = hwStart & transactionActive_q;

    wire accDone   = memReq_q.valid & memAck & ~killAll;
    wire readDone  = accDone & (state_q == ST_READ);
    wire writeDone = accDone & (state_q == ST_WRITE);
    wire srcLast   = (srcCnt_q == `DMACC_CNT_ONE);
    wire dstLast   = (dstCnt_q == `DMACC_CNT_ONE);
    wire srcDone   = writeDone & srcLast;
    wire dstDone   = writeDone & dstLast;
    wire msgEnd    = srcDone | dstDone;

    // ****************************************************************
    // pointers and counts
    // ****************************************************************
    // (RQ8) advance or reload each pair
    assign srcPtr_d = wrSStart ? wd[`DMACC_ADDR_W-1:0] :
                      srcDone  ? srcStart_q :
                      writeDone ? srcPtr_q + 16'h0001 : srcPtr_q;
    assign dstPtr_d = wrDStart ? wd[`DMACC_ADDR_W-1:0] :
                      dstDone  ? dstStart_q :
                      writeDone ? dstPtr_q + 16'h0001 : dstPtr_q;
    assign srcCnt_d = wrSSize  ? wd[`DMACC_CNT_W-1:0] :
                      srcDone  ? srcSize_q :
                      writeDone ? srcCnt_q - `DMACC_CNT_ONE : srcCnt_q;
    assign dstCnt_d = wrDSize  ? wd[`DMACC_CNT_W-1:0] :
                      dstDone  ? dstSize_q :
                      writeDone ? dstCnt_q - `DMACC_CNT_ONE : dstCnt_q;

    // (RQ4) active from start to last write, abort or disable
    assign transactionActive_d = killAll  ? 1'b0 :
                                 beginMsg ? 1'b1 :
                                 msgEnd   ? 1'b0 : transactionActive_q;
    // (RQ6) buffer holds a word between read and write
    assign heldDataPending_d = killAll   ? 1'b0 :
                               readDone  ? 1'b1 :
                               writeDone ? 1'b0 : heldDataPending_q;

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_comb begin
        state_d  = state_q;
        memReq_d = memReq_q;
        if (accDone) begin
            memReq_d.valid = 1'b0;
        end
        case (state_q)
            ST_IDLE: begin
                if (beginMsg) begin
                    state_d        = ST_READ;
                    memReq_d.valid = 1'b1;
                    memReq_d.write = 1'b0;
                    memReq_d.addr  = srcPtr_q;
                end
            end
            // (RQ8) source read first
            ST_READ: begin
                if (readDone) begin
                    state_d        = ST_WRITE;
                    memReq_d.valid = 1'b1;
                    memReq_d.write = 1'b1;
                    memReq_d.addr  = dstPtr_q;
                    memReq_d.wdata = memRdata;
                end
            end
            // (RQ8) then destination write
            ST_WRITE: begin
                if (msgEnd) begin
                    state_d = ST_IDLE;
                end else if (writeDone) begin
                    state_d        = ST_READ;
                    memReq_d.valid = 1'b1;
                    memReq_d.write = 1'b0;
                    memReq_d.addr  = srcPtr_d;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // disable or abort withdraws any pending access
        if (killAll) begin
            state_d        = ST_IDLE;
            memReq_d.valid = 1'b0;
        end
    end

    // ****************************************************************
    // interrupt status
    // ****************************************************************
    assign intEvent[`DMACC_INT_OVR]   = overrun;
    assign intEvent[`DMACC_INT_SDONE] = srcDone;
    assign intEvent[`DMACC_INT_DDONE] = dstDone;
    assign intEvent[`DMACC_INT_ABORT] = abortHit;

    // a new event wins over a write-one-to-clear in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < `DMACC_NUM_INT; gi++) begin : g_sticky
            assign intStat_d[gi] = intEvent[gi] |
                                   (intStat_q[gi] & ~(wrIStat & wd[gi]));
        end
    endgenerate

    // ****************************************************************
    // read mux
    // ****************************************************************
    // (RQ7) unused control bits forced to zero
    wire [7:0] ctrlRd = {enable_q, hwStartPermit_q, transactionActive_q,
                         2'b00, hwAbortPermit_q, 1'b0, heldDataPending_q};
    assign regRdata =
        ({32{hitCtrl}}   & {24'h000000, ctrlRd}) |
        ({32{hitSStart}} & {16'h0000, srcStart_q}) |
        ({32{hitSSize}}  & {20'h00000, srcSize_q}) |
        ({32{hitDStart}} & {16'h0000, dstStart_q}) |
        ({32{hitDSize}}  & {20'h00000, dstSize_q}) |
        ({32{hitSPtr}}   & {16'h0000, srcPtr_q}) |
        ({32{hitDPtr}}   & {16'h0000, dstPtr_q}) |
        ({32{hitSCnt}}   & {20'h00000, srcCnt_q}) |
        ({32{hitDCnt}}   & {20'h00000, dstCnt_q}) |
        ({32{hitBuf}}    & {24'h000000, holdBuf_q}) |
        ({32{hitIStat}}  & {28'h0000000, intStat_q}) |
        ({32{hitIMask}}  & {28'h0000000, intMask_q});

    // ****************************************************************
    // control register
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_q        <= 1'b0;
            hwStartPermit_q <= 1'b0;
            hwAbortPermit_q <= 1'b0;
        end else begin
            // (RQ2) enable follows software
            if (wrCtrl) begin
                enable_q        <= wd[`DMACC_CTRL_EN];
                hwStartPermit_q <= wd[`DMACC_CTRL_HSP];
                hwAbortPermit_q <= wd[`DMACC_CTRL_HAP];
            end else if (abortHit) begin
                // (RQ5) abort permit is spent by the abort
                hwAbortPermit_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // channel state
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q             <= ST_IDLE;
            transactionActive_q <= 1'b0;
            heldDataPending_q   <= 1'b0;
            memReq_q            <= '0;
            holdBuf_q           <= `DMACC_BUF_RST;
        end else begin
            state_q             <= state_d;
            transactionActive_q <= transactionActive_d;
            heldDataPending_q   <= heldDataPending_d;
            memReq_q            <= memReq_d;
            if (readDone) begin
                holdBuf_q <= memRdata;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            srcStart_q <= `DMACC_ADDR_RST;
            dstStart_q <= `DMACC_ADDR_RST;
            srcSize_q  <= `DMACC_CNT_RST;
            dstSize_q  <= `DMACC_CNT_RST;
        end else begin
            if (wrSStart) begin
                srcStart_q <= wd[`DMACC_ADDR_W-1:0];
            end
            if (wrDStart) begin
                dstStart_q <= wd[`DMACC_ADDR_W-1:0];
            end
            if (wrSSize) begin
                srcSize_q <= wd[`DMACC_CNT_W-1:0];
            end
            if (wrDSize) begin
                dstSize_q <= wd[`DMACC_CNT_W-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            srcPtr_q <= `DMACC_ADDR_RST;
            dstPtr_q <= `DMACC_ADDR_RST;
            srcCnt_q <= `DMACC_CNT_RST;
            dstCnt_q <= `DMACC_CNT_RST;
        end else begin
            srcPtr_q <= srcPtr_d;
            dstPtr_q <= dstPtr_d;
            srcCnt_q <= srcCnt_d;
            dstCnt_q <= dstCnt_d;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            intStat_q <= `DMACC_INT_RST;
            intMask_q <= `DMACC_INT_RST;
            irq_q     <= 1'b0;
        end else begin
            intStat_q <= intStat_d;
            if (wrIMask) begin
                intMask_q <= wd[`DMACC_NUM_INT-1:0];
            end
            irq_q <= |(intStat_d & intMask_q);
        end
    end

    assign memReq = memReq_q;
    assign irq    = irq_q;
endmodule : dmacc_channel_ctrl

// ---- rtl/dmacc_params.svh ----
// Purpose: constants of the dma channel control core
// Assumes: included by the package and by every design file
// Notes:   byte offsets on a 32-bit register bus, one word per register
`ifndef DMACC_PARAMS_SVH
`define DMACC_PARAMS_SVH

// ****
// widths
// ****
`define DMACC_ADDR_W      16
`define DMACC_CNT_W       12
`define DMACC_DATA_W      8
`define DMACC_NUM_INT     4
`define DMACC_CNT_ONE     12'h001

// ****
// register byte offsets
// ****
`define DMACC_OFF_CTRL    8'h00
`define DMACC_OFF_SSTART  8'h04
`define DMACC_OFF_SSIZE   8'h08
`define DMACC_OFF_DSTART  8'h0c
`define DMACC_OFF_DSIZE   8'h10
`define DMACC_OFF_SPTR    8'h14
`define DMACC_OFF_DPTR    8'h18
`define DMACC_OFF_SCNT    8'h1c
`define DMACC_OFF_DCNT    8'h20
`define DMACC_OFF_BUF     8'h24
`define DMACC_OFF_ISTAT   8'h28
`define DMACC_OFF_IMASK   8'h2c

// ****
// field positions
// ****
`define DMACC_CTRL_EN     7
`define DMACC_CTRL_HSP    6
`define DMACC_CTRL_ACT    5
`define DMACC_CTRL_HAP    2
`define DMACC_CTRL_HELD   0
`define DMACC_INT_OVR     0
`define DMACC_INT_SDONE   1
`define DMACC_INT_DDONE   2
`define DMACC_INT_ABORT   3

// ****
// reset values
// ****
`define DMACC_CTRL_RST    8'h00
`define DMACC_ADDR_RST    16'h0000
`define DMACC_CNT_RST     12'h000
`define DMACC_BUF_RST     8'h00
`define DMACC_INT_RST     4'h0
`define DMACC_WORD_RST    32'h00000000
`define DMACC_HSIZE_WORD  3'h2

`endif

// ---- rtl/dmacc_pkg.sv ----
// Purpose: shared types of the dma channel control core
// Assumes: constants come from dmacc_params.svh
// Notes:   none
package dmacc_pkg;
    `include "dmacc_params.svh"

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE
    } dmacc_state_e;

    // one memory access request, held until acknowledged
    typedef struct packed {
        logic                     valid;
        logic                     write;
        logic [`DMACC_ADDR_W-1:0] addr;
        logic [`DMACC_DATA_W-1:0] wdata;
    } dmacc_mem_req_s;

    // register access from the bus slave to the core
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } dmacc_reg_acc_s;

    typedef logic [`DMACC_NUM_INT-1:0] dmacc_int_t;
endpackage : dmacc_pkg

// ---- verif/dmacc_channel_ctrl_asserts.sv ----
// Purpose: port assertions of the dma channel control core
// Assumes: sees only the top module ports
// Notes:   abort cycles are left out of the hold checks
`timescale 1ns/1ps
module dmacc_channel_ctrl_asserts (
    // clock and reset
    input wire logic                 sys_clk,
    input wire logic                 rst_n,
    // register bus
    input wire logic                 hsel,
    input wire logic [1:0]           htrans,
    input wire logic                 hwrite,
    input wire logic [2:0]           hsize,
    input wire logic                 hready,
    input wire logic                 hreadyout,
    input wire logic                 hresp,
    // trigger and memory
    input wire logic                 abortTrig,
    input dmacc_pkg::dmacc_mem_req_s memReq,
    input wire logic                 memAck,
    input wire logic [7:0]           memRdata
);
    import dmacc_pkg::*;
    wire take   = hsel && htrans[1] && hready && hsize == 3'h2;
    wire rdTake = take && !hwrite;
    wire wrTake = take && hwrite;
    wire rdAck  = memReq.valid && !memReq.write && memAck;
    wire wrAck  = memReq.valid && memReq.write && memAck;
    // ****
    // properties
    // ****
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    chk_resp_okay:
        assert property (hresp == 1'b0) else $error("bad response");
    chk_write_nowait:
        assert property (wrTake |=> hreadyout) else $error("write stall");
    chk_read_wait:
        assert property (rdTake |=> !hreadyout ##1 hreadyout)
        else $error("read wait wrong");
    chk_ready_cause:
        assert property (!hreadyout |-> $past(rdTake))
        else $error("stray wait state");
    chk_req_held:
        assert property (memReq.valid && !memAck && !abortTrig
            |=> $stable(memReq)) else $error("request changed");
    chk_write_follows:
        assert property (rdAck && !abortTrig |=> memReq.valid
            && memReq.write && memReq.wdata == $past(memRdata))
        else $error("write not after read");
    chk_first_read:
        assert property ($rose(memReq.valid) |-> !memReq.write)
        else $error("step began with write");
    chk_after_write:
        assert property (wrAck |=> !(memReq.valid && memReq.write))
        else $error("two writes in a row");
endmodule : dmacc_channel_ctrl_asserts

bind dmacc_channel_ctrl dmacc_channel_ctrl_asserts u_chk (.sys_clk,
    .rst_n, .hsel, .htrans, .hwrite, .hsize, .hready, .hreadyout,
    .hresp, .abortTrig, .memReq, .memAck, .memRdata);

// ---- verif/dmacc_mem_model.sv ----
// Purpose: system memory seen by the channel
// Assumes: one request at a time, held until acknowledged
// Notes:   slow mode stretches writes so held data can be seen
`timescale 1ns/1ps
module dmacc_mem_model (
    // clock and reset
    input wire logic                 sys_clk,
    input wire logic                 rst_n,
    // memory side
    input dmacc_pkg::dmacc_mem_req_s memReq,
    input wire logic                 slow,
    output logic                     memAck,
    output logic [7:0]               memRdata,
    // write record
    output logic [15:0]              lastAddr,
    output logic [7:0]               lastData,
    output logic [7:0]               wrCount
);
    import dmacc_pkg::*;
    logic [4:0] waitQ;
    wire  [4:0] need = (slow && memReq.write) ? 5'h14 : 5'h01;
    assign memAck = memReq.valid && waitQ >= need;
    // bytes only valid in the ack cycle, inverted otherwise
    assign memRdata = memAck ? memReq.addr[7:0] ^ 8'h5a
                             : ~(memReq.addr[7:0] ^ 8'h5a);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            waitQ    <= 5'h00;
            lastAddr <= 16'h0000;
            lastData <= 8'h00;
            wrCount  <= 8'h00;
        end else begin
            waitQ <= (memReq.valid && !memAck) ? waitQ + 5'h01 : 5'h00;
            if (memAck && memReq.write) begin
                lastAddr <= memReq.addr;
                lastData <= memReq.wdata;
                wrCount  <= wrCount + 8'h01;
            end
        end
    end
endmodule : dmacc_mem_model

// ---- verif/dmacc_tb.sv ----
// Purpose: self-checking bench of the dma channel control core
// Assumes: AHB-Lite master tasks, memory model on the far side
// Notes:   expected bytes follow the memory model's address pattern
`timescale 1ns/1ps
module tb;
    import dmacc_pkg::*;
    logic sys_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, slow = 0;
    logic startTrig = 0, abortTrig = 0, hreadyout, hresp, memAck, irq;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rv, d, seed;
    logic [15:0] s, dA, lastAddr;
    logic [7:0] memRdata, lastData, wrCount, n0;
    int errors = 0, checks = 0;
    dmacc_mem_req_s memReq;
    always #5 sys_clk = ~sys_clk;
    dmacc_channel_ctrl dut (.sys_clk, .rst_n, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .startTrig, .abortTrig, .memReq, .memAck, .memRdata,
        .irq);
    dmacc_mem_model mem (.sys_clk, .rst_n, .memReq, .slow, .memAck,
        .memRdata, .lastAddr, .lastData, .wrCount);
    // ****
    // tasks
    // ****
    function automatic logic [7:0] byteAt(input logic [15:0] a);
        return a[7:0] ^ 8'h5a;
    endfunction : byteAt
    task automatic conclude;
        if (errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic waitRdy;
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            errors++;
            conclude();
        end
    endtask : waitRdy
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        waitRdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        waitRdy();
        rv = hrdata;
    endtask : ahb
    task automatic pulse(input logic abort);
        startTrig <= !abort;
        abortTrig <= abort;
        @(posedge sys_clk);
        startTrig <= 1'b0;
        abortTrig <= 1'b0;
    endtask : pulse
    task automatic waitIdle;
        for (int i = 0; i < 300; i++) begin
            ahb(0, 8'h00, 0);
            if (rv[5] === 1'b0)
                return;
        end
        errors++;
        conclude();
    endtask : waitIdle
    // ****
    // scenarios
    // ****
    initial begin
        seed = 32'h4f70;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        ahb(0, 8'h00, 0); chk(rv, 32'h0);
        for (int i = 0; i < 6; i++) begin
            d = $random(seed) & 32'hdf;
            ahb(1, 8'h00, d);
            ahb(0, 8'h00, 0); chk(rv, d & 32'hc4);
        end
        s = $random(seed);
        dA = $random(seed);
        ahb(1, 8'h04, {16'h0, s});
        ahb(1, 8'h08, 2);
        ahb(1, 8'h0c, {16'h0, dA});
        ahb(1, 8'h10, 4);
        ahb(1, 8'h00, 32'hc4);
        slow <= 1'b1;
        pulse(0);
        repeat (4) @(posedge sys_clk);
        ahb(0, 8'h00, 0); chk(rv, 32'he5);
        pulse(0);
        waitIdle();
        ahb(0, 8'h28, 0); chk(rv, 32'h3);
        ahb(0, 8'h14, 0); chk(rv, {16'h0, s});
        ahb(0, 8'h18, 0); chk(rv, {16'h0, dA + 16'h2});
        ahb(0, 8'h20, 0); chk(rv, 32'h2);
        chk({24'h0, lastData}, {24'h0, byteAt(s + 16'h1)});
        chk({16'h0, lastAddr}, {16'h0, dA + 16'h1});
        ahb(1, 8'h2c, 1);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        ahb(1, 8'h28, 1);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        n0 = wrCount;
        ahb(1, 8'h00, 32'h84);
        pulse(0);
        repeat (30) @(posedge sys_clk);
        ahb(0, 8'h00, 0); chk(rv, 32'h84);
        chk({24'h0, wrCount}, {24'h0, n0});
        ahb(1, 8'h00, 32'hc4);
        pulse(0);
        repeat (6) @(posedge sys_clk);
        pulse(1);
        repeat (2) @(posedge sys_clk);
        ahb(0, 8'h00, 0); chk(rv, 32'hc0);
        ahb(0, 8'h28, 0); chk(rv, 32'ha);
        ahb(1, 8'h28, 32'hf);
        ahb(1, 8'h00, 32'he0);
        slow <= 1'b0;
        repeat (3) @(posedge sys_clk);
        pulse(1);
        waitIdle();
        ahb(0, 8'h28, 0); chk(rv, 32'h6);
        ahb(0, 8'h3c, 0); chk(rv, 32'h0);
        conclude();
    end
endmodule : tb
